// File: hw/srcp_port.sv
// serial register control port: instruction decode, register file, readback
//
// Functional notes
// - each cycle starts with an eight-bit instruction byte, then a data phase
// - instruction top bit one means read, zero means write
// - byte count field 00..11 gives one to four data bytes
// - low five bits give first address, later addresses made internally
// - written register updates when the last bit of its byte arrives
// - sample input on sclk rise, change read data on sclk fall
// - low chip select starts a cycle; high floats both data outputs
// - config bit 7 default zero: data pin input only, reads on out pin
// - in bidirectional mode the separate out pin stays floating
// - config bit order selects lsb-first or msb-first bytes
// - address increments in lsb-first mode, decrements in msb-first mode
// - address wraps 0x1F to 0x00 and 0x00 to 0x1F
// - new config applies from the next bit, mid-cycle too
// - mirrored reset write loads config and resets other registers
// - reset bit returns all registers but zero to defaults
// - every consistent config write reprograms multiplier; 200 mclk settle time
// - config bit 6 high means lsb first, low msb first
// - config bit 7 high means three-wire port, low four-wire
`timescale 1ns/10ps
module srcp_port (
	input wire logic clk, // system clock, 50 MHz
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic sclk, // serial clock from host
	input wire logic cs_n, // chip select, active low
	input wire logic sdio_in, // serial data pin, input side
	output logic sdio_out, // serial data pin, output side
	output logic sdio_oe, // serial data pin drive enable
	output logic serial_out_pin, // separate serial output
	output logic serial_out_oe, // separate serial output drive enable
	output logic [255:0] cfg_regs, // all 32 registers, address 0 lowest
	output logic clk_mult_reprog, // one-cycle pulse: reprogram multiplier
	output logic clk_settling // high while system clock settles
);
	import srcp_pkg::*;

	logic sclk_s;
	logic cs_n_s;
	logic sdio_s;
	logic sclk_q;
	logic sclk_rise;
	logic sclk_fall;
	srcp_state_t state_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic read_q;
	logic [1:0] bytes_left_q;
	logic [4:0] addr_q;
	logic [4:0] addr_d;
	logic byte_done;
	logic wr_byte;
	logic lsb_first;
	logic bidir;
	logic mirrored;
	logic consistent;
	logic [7:0] settle_q;
	logic [7:0] regs_q [REG_CNT];

	// ==========================================================
	// input synchronisers
	srcp_sync #(.RST_VAL(1'b0)) u_sync_sclk (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.d(sclk),
		.q(sclk_s)
	);

	srcp_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.d(cs_n),
		.q(cs_n_s)
	);

	srcp_sync #(.RST_VAL(1'b0)) u_sync_sdio (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.d(sdio_in),
		.q(sdio_s)
	);

	// ==========================================================
	// serial clock edge detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			sclk_q <= 1'b0;
		else if (ce)
			sclk_q <= sclk_s;
	end

	assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;

	// ==========================================================
	// live port configuration, read straight from register zero
	assign lsb_first = regs_q[CFG_ADDR][CFG_LSB_BIT];
	assign bidir = regs_q[CFG_ADDR][CFG_BIDIR_BIT];

	// shift in one bit in the selected order
	always_comb
	begin
		if (lsb_first)
			shift_d = {sdio_s, shift_q[7:1]};
		else
			shift_d = {shift_q[6:0], sdio_s};
	end

	assign byte_done = sclk_rise && (bit_cnt_q == LAST_BIT);
	assign wr_byte = byte_done && (state_q == SRCP_DATA) && !read_q;

	// next address: up in lsb-first mode, down otherwise, 5-bit wrap
	always_comb
	begin
		if (lsb_first)
			addr_d = addr_q + 5'h01;
		else
			addr_d = addr_q - 5'h01;
	end

	// symmetric pattern XYZWWZYX on the incoming config byte
	assign mirrored = (shift_d[0] == shift_d[7]) && (shift_d[1] == shift_d[6])
		&& (shift_d[2] == shift_d[5]) && (shift_d[3] == shift_d[4]);
	// same port configuration echoed with reset low
	assign consistent = (shift_d[0] == shift_d[7]) && (shift_d[1] == shift_d[6])
		&& !shift_d[CFG_RST_BIT];

	// ==========================================================
	// cycle sequencer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= SRCP_IDLE;
		else if (ce)
		begin
			if (cs_n_s)
				state_q <= SRCP_IDLE;
			else
			begin
				case (state_q)
					SRCP_IDLE:
						state_q <= SRCP_INSTR;
					SRCP_INSTR:
						if (byte_done)
							state_q <= SRCP_DATA;
					SRCP_DATA:
						if (byte_done && bytes_left_q == 2'h0)
							state_q <= SRCP_DONE;
					SRCP_DONE:
						state_q <= SRCP_DONE;
					default:
						state_q <= SRCP_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// bit counter and shift register, cleared when the host deselects
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
		end
		else if (ce)
		begin
			if (cs_n_s || state_q == SRCP_IDLE)
			begin
				bit_cnt_q <= 3'h0;
				shift_q <= 8'h00;
			end
			else if (sclk_rise)
			begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				shift_q <= shift_d;
			end
		end
	end

	// ==========================================================
	// instruction decode and address generator
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			read_q <= 1'b0;
			bytes_left_q <= 2'h0;
			addr_q <= 5'h00;
		end
		else if (ce && byte_done)
		begin
			if (state_q == SRCP_INSTR)
			begin
				read_q <= shift_d[INSTR_RW_BIT];
				bytes_left_q <= shift_d[INSTR_CNT_HI:INSTR_CNT_LO];
				addr_q <= shift_d[INSTR_ADDR_HI:0];
			end
			else if (state_q == SRCP_DATA)
			begin
				bytes_left_q <= bytes_left_q - 2'h1;
				addr_q <= addr_d;
			end
		end
	end

	// ==========================================================
	// register file with immediate byte writes and soft reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < REG_CNT; i++)
				regs_q[i] <= (5'(i) == VIDEO_ADDR) ? VIDEO_DEFAULT : REG_DEFAULT;
		end
		else if (ce && wr_byte)
		begin
			if (addr_q != CFG_ADDR)
				regs_q[addr_q] <= shift_d;
			else if (shift_d[CFG_RST_BIT])
			begin
				// every other register back to default; reset bit self-clears
				for (int i = 1; i < REG_CNT; i++)
					regs_q[i] <= (5'(i) == VIDEO_ADDR) ? VIDEO_DEFAULT
						: REG_DEFAULT;
				if (mirrored)
					regs_q[CFG_ADDR] <= shift_d & ~(8'h01 << CFG_RST_BIT);
			end
			else
				regs_q[CFG_ADDR] <= shift_d;
		end
	end

	// ==========================================================
	// multiplier reprogram pulse and settle window
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clk_mult_reprog <= 1'b0;
			clk_settling <= 1'b0;
			settle_q <= 8'h00;
		end
		else if (ce)
		begin
			clk_mult_reprog <= 1'b0;
			if (wr_byte && addr_q == CFG_ADDR && consistent)
			begin
				clk_mult_reprog <= 1'b1;
				clk_settling <= 1'b1;
				settle_q <= SETTLE_CNT;
			end
			else if (settle_q != 8'h00)
			begin
				settle_q <= settle_q - 8'h01;
				clk_settling <= (settle_q != 8'h01);
			end
		end
	end

	// ==========================================================
	// read data out on the falling edge, routed by the pin mode
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
			serial_out_pin <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else if (ce)
		begin
			if (cs_n_s || !read_q || state_q == SRCP_IDLE
				|| state_q == SRCP_INSTR)
			begin
				sdio_oe <= 1'b0;
				serial_out_oe <= 1'b0;
			end
			else if (sclk_fall && state_q == SRCP_DATA)
			begin
				sdio_out <= regs_q[addr_q][lsb_first ? bit_cnt_q
					: LAST_BIT - bit_cnt_q];
				serial_out_pin <= regs_q[addr_q][lsb_first ? bit_cnt_q
					: LAST_BIT - bit_cnt_q];
				sdio_oe <= bidir;
				serial_out_oe <= ~bidir;
			end
		end
	end

	// ==========================================================
	// flatten the register file for the rest of the chip
	for (genvar g = 0; g < REG_CNT; g++)
	begin : g_flat
		assign cfg_regs[g*BYTE_W +: BYTE_W] = regs_q[g];
	end
endmodule : srcp_port

// File: hw/srcp_pkg.sv
// constants and types shared by the serial register control port
package srcp_pkg;
	// ==========================================================
	// register file shape
	localparam int REG_CNT = 32;
	localparam int ADDR_W = 5;
	localparam int BYTE_W = 8;
	localparam logic [4:0] CFG_ADDR = 5'h00;
	localparam logic [4:0] VIDEO_ADDR = 5'h07;
	localparam logic [7:0] REG_DEFAULT = 8'h00;
	localparam logic [7:0] VIDEO_DEFAULT = 8'h20;
	// ==========================================================
	// port configuration register fields
	localparam int CFG_BIDIR_BIT = 7;
	localparam int CFG_LSB_BIT = 6;
	localparam int CFG_RST_BIT = 5;
	// ==========================================================
	// instruction byte fields
	localparam int INSTR_RW_BIT = 7;
	localparam int INSTR_CNT_HI = 6;
	localparam int INSTR_CNT_LO = 5;
	localparam int INSTR_ADDR_HI = 4;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCLK_MAX_MHZ = 15;
	localparam int SETTLE_MCLK = 200;
	localparam int MCLK_PERIOD_NS = 20;
	localparam int SETTLE_CYCLES =
		(SETTLE_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYCLES);
	// ==========================================================
	// serial port sequencer states
	typedef enum logic [1:0] {
		SRCP_IDLE,
		SRCP_INSTR,
		SRCP_DATA,
		SRCP_DONE
	} srcp_state_t;
endpackage : srcp_pkg

// File: hw/srcp_sync.sv
// two flip-flop synchroniser for one asynchronous input
`timescale 1ns/10ps
module srcp_sync #(
	parameter logic RST_VAL = 1'b0 // value held during reset
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic d, // asynchronous input
	output logic q // synchronised output
);
	logic meta_q;

	// ==========================================================
	// two stages, only the second one is visible outside
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end
		else if (ce)
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : srcp_sync

// File: testbench/srcp_host.sv
// host serial master model driving the serial register control port
`timescale 1ns/10ps
module srcp_host (
	input wire logic clk, // system clock
	input wire logic rd_line, // resolved read line
	output logic sclk, // serial clock, idles high
	output logic cs_n, // chip select, active low
	output logic sdi // host data onto the data pin
);
	// ==========================================================
	// idle levels at time zero
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// wait n clock edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// one whole cycle of n bits: instruction, then data bytes
	task automatic xfer(input logic [7:0] ins, input int n, input logic lsb,
		input logic [31:0] wd, output logic [31:0] rd);
		logic [7:0] b;
		int j;
		rd = '0;
		tick(1);
		cs_n = 1'b0;
		tick(4);
		for (int i = 0; i < n; i++)
		begin
			j = lsb ? i % 8 : 7 - i % 8;
			b = (i < 8) ? ins : wd[8*((i/8+3)%4)+:8];
			sclk = 1'b0;
			sdi = (ins[7] && i >= 8) ? i[0] : b[j];
			tick(4);
			sclk = 1'b1;
			tick(4);
			if (i >= 8) rd[8*((i/8+3)%4)+j] = rd_line;
		end
		cs_n = 1'b1;
		tick(8);
	endtask : xfer
endmodule : srcp_host

// File: testbench/srcp_properties.sv
// assertions on the ports of the serial register control port
`timescale 1ns/10ps
module srcp_properties (
	input wire logic clk, // system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic sclk, // serial clock
	input wire logic cs_n, // chip select
	input wire logic sdio_in, // data pin input
	input wire logic sdio_out, // data pin output
	input wire logic sdio_oe, // data pin enable
	input wire logic serial_out_pin, // separate output
	input wire logic serial_out_oe, // separate output enable
	input wire logic [255:0] cfg_regs, // register file
	input wire logic clk_mult_reprog, // reprogram pulse
	input wire logic clk_settling // settle window
);
	import srcp_pkg::*;
	logic [8:0] n_q;
	// ==========================================================
	// length of the settle window
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) n_q <= '0;
		else if (clk_mult_reprog) n_q <= 9'h001; // pulse cycle counts as one
		else if (clk_settling) n_q <= n_q + 9'h001;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	idle_float_a: assert property (cs_n [*6] |-> !sdio_oe && !serial_out_oe)
		else $error("output driven while deselected");
	bidir_quiet_a: assert property (cfg_regs[7] |-> !serial_out_oe)
		else $error("separate output driven in three-wire mode");
	four_wire_a: assert property (!cfg_regs[7] |-> !sdio_oe)
		else $error("data pin driven in four-wire mode");
	oe_in_cycle_a: assert property ($rose(sdio_oe || serial_out_oe)
		|-> !cs_n && !sclk) else $error("drive began off a falling edge");
	out_on_fall_a: assert property ($changed(serial_out_pin) &&
		serial_out_oe && $past(serial_out_oe) |-> !$past(sclk))
		else $error("read data moved off a falling edge");
	commit_rise_a: assert property ($changed(cfg_regs)
		|-> !$past(cs_n) && $past(sclk)) else $error("register moved off a rise");
	pulse_once_a: assert property (clk_mult_reprog |=> !clk_mult_reprog)
		else $error("reprogram pulse too long");
	settle_on_a: assert property (clk_mult_reprog |=> clk_settling [*8])
		else $error("settle window missing");
	settle_len_a: assert property ($fell(clk_settling)
		|-> n_q == 9'(SETTLE_CYCLES)) else $error("settle window length");
	cover property (clk_mult_reprog);
	cover property ($rose(sdio_oe));
	cover property ($rose(serial_out_oe));
endmodule : srcp_properties
bind srcp_port srcp_properties chk (.clk(clk), .arst_n(arst_n), .ce(ce),
	.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
	.sdio_oe(sdio_oe), .serial_out_pin(serial_out_pin),
	.serial_out_oe(serial_out_oe), .cfg_regs(cfg_regs),
	.clk_mult_reprog(clk_mult_reprog), .clk_settling(clk_settling));

// File: testbench/test_serial_register_control_port.sv
// self-checking bench for the serial register control port
`timescale 1ns/10ps
module test_serial_register_control_port;
	import srcp_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic sclk, cs_n, h_sdi, sdio_out, sdio_oe, so_pin, so_oe, mult, settle;
	logic [255:0] regs;
	logic [7:0] m [32];
	logic [7:0] cfgs [4] = '{8'h40, 8'hC0, 8'h80, 8'h00};
	logic [31:0] s = 32'h000180BA;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_pulse = 0;
	int n_pulse_exp = 0;
	wire sdio_w = sdio_oe ? sdio_out : h_sdi;
	wire h_rd = m[0][7] ? sdio_w : (so_oe ? so_pin : ~h_sdi);
	// ==========================================================
	// clock
	always #10 clk = ~clk;
	srcp_port DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1), .sclk(sclk),
		.cs_n(cs_n), .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.serial_out_pin(so_pin), .serial_out_oe(so_oe), .cfg_regs(regs),
		.clk_mult_reprog(mult), .clk_settling(settle));
	srcp_host H (.clk(clk), .rd_line(h_rd), .sclk(sclk), .cs_n(cs_n),
		.sdi(h_sdi));
	// xorshift source of stimulus
	function automatic logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	// byte compare
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	// model of one register write
	task automatic mwr(input logic [4:0] a, input logic [7:0] v);
		if (a == CFG_ADDR && v[CFG_RST_BIT])
		begin
			for (int i = 1; i < REG_CNT; i++)
				m[i] = (5'(i) == VIDEO_ADDR) ? VIDEO_DEFAULT : REG_DEFAULT;
			if (v[0] == v[7] && v[1] == v[6] && v[2] == v[5] && v[3] == v[4])
				m[0] = v & 8'hDF;
		end
		else
		begin
			m[a] = v;
			// consistent echo with reset low asks for a multiplier reprogram
			if (a == CFG_ADDR && v[0] == v[7] && v[1] == v[6])
				n_pulse_exp++;
		end
	endtask : mwr
	// count reprogram pulses seen on the design output
	always @(posedge clk)
	begin
		if (mult === 1'b1)
			n_pulse++;
	end
	// one cycle with checks; bytes bound for register zero carry v0
	task automatic run(input logic rw, input int nb, input logic [4:0] a,
		input int nbits, input logic [7:0] v0);
		logic [31:0] wd;
		logic [31:0] rd;
		logic [4:0] ad;
		logic lsb;
		lsb = m[0][CFG_LSB_BIT];
		wd = xs();
		ad = a;
		for (int k = 0; k < nb; k++)
		begin
			if (ad == CFG_ADDR) wd[8*k+:8] = v0;
			ad = lsb ? ad + 5'h01 : ad - 5'h01;
		end
		H.xfer({rw, 2'(nb - 1), a}, nbits, lsb, wd, rd);
		ad = a;
		for (int k = 0; k < nb && nbits == 8 + 8 * nb; k++)
		begin
			if (rw) cmp(rd[8*k+:8], m[ad]);
			else mwr(ad, wd[8*k+:8]);
			ad = lsb ? ad + 5'h01 : ad - 5'h01;
		end
		for (int i = 0; i < REG_CNT; i++) cmp(regs[8*i+:8], m[i]);
		cmp(8'(n_pulse), 8'(n_pulse_exp));
	endtask : run
	// verdict
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// cut a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 30000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// main sequence
	initial
	begin
		logic [31:0] x;
		int nb;
		for (int i = 0; i < REG_CNT; i++)
			m[i] = (5'(i) == VIDEO_ADDR) ? VIDEO_DEFAULT : REG_DEFAULT;
		repeat (6) @(posedge clk);
		#1 arst_n = 1'b1;
		for (int t = 0; t < 4; t++)
		begin
			run(1'b1, 4, m[0][CFG_LSB_BIT] ? 5'h1E : 5'h00, 40, m[0]);
			for (int r = 0; r < 5; r++)
			begin
				x = xs();
				nb = int'(x[9:8]) + 1;
				run(x[0], nb, x[4:0], 8 + 8 * nb, m[0]);
			end
			run(1'b0, 1, CFG_ADDR, 16, cfgs[t]);
		end
		run(1'b0, 2, 5'h09, 13, m[0]);
		run(1'b0, 1, 5'h09, 16, m[0]);
		run(1'b0, 1, CFG_ADDR, 16, 8'h20);
		run(1'b0, 2, 5'h0C, 24, m[0]);
		run(1'b0, 1, CFG_ADDR, 16, 8'h24);
		tally_and_finish();
	end
endmodule : test_serial_register_control_port
